// *** ulpi_phy_consts.vh ***
// constants for the ulpi rx command and transmit framing block
`ifndef ULPI_PHY_CONSTS_VH
`define ULPI_PHY_CONSTS_VH
`define DATA_W          8
`define FIFO_DEPTH      16
`define FIFO_AW         4
`define ULPI_IDLE       8'h00
`define TXCMD_TX        2'h1
`define OPM_NORMAL      2'h0
`define OPM_NODRIVE     2'h1
`define OPM_CHIRP       2'h2
`define XS_HS           2'h0
`define VB_BELOW_END    2'h0
`define VB_SESS_LOW     2'h1
`define VB_SESS_OK      2'h2
`define VB_SUPPLY_OK    2'h3
`define EV_NONE         2'h0
`define EV_ACTIVE       2'h1
`define EV_ERROR        2'h3
`define EV_UNPLUG       2'h2
`define SYNC_HS_BITS    6'h20
`define SYNC_FL_BITS    6'h08
`define STUFF_LIMIT     3'h6
`define FS_DIV          6'h28
`define LS_DIV          9'h140
`endif

// *** sync_fifo.v ***
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
module sync_fifo #(
	parameter WIDTH = 8,
	parameter DEPTH = 16,
	parameter AW    = 4
) (
	input  wire             clk,
	input  wire             rstn,
	input  wire [WIDTH-1:0] in_data,
	input  wire             in_valid,
	output wire             in_ready,
	output reg  [WIDTH-1:0] out_data,
	output wire             out_valid,
	input  wire             out_ready,
	output wire             empty
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW:0]      wp_q;
	reg [AW:0]      rp_q;
	reg             ov_q;
	wire            full = (wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]);
	wire            mt   = (wp_q == rp_q);
	wire            pop  = !mt && (!ov_q || out_ready);
	assign in_ready  = !full;
	assign out_valid = ov_q;
	assign empty     = mt && !ov_q;
	always @(posedge clk) begin
		if (in_valid && !full)
			mem[wp_q[AW-1:0]] <= in_data;
		if (pop)
			out_data <= mem[rp_q[AW-1:0]];
	end
	always @(posedge clk) begin
		if (!rstn) begin
			wp_q <= {(AW+1){1'b0}};
			rp_q <= {(AW+1){1'b0}};
			ov_q <= 1'b0;
		end else begin
			if (in_valid && !full)
				wp_q <= wp_q + 1'b1;
			if (pop)
				rp_q <= rp_q + 1'b1;
			if (pop)
				ov_q <= 1'b1;
			else if (out_ready)
				ov_q <= 1'b0;
		end
	end
endmodule // sync_fifo

// *** tx_line_coder.v ***
// serial bit stuffer and nrzi coder for outgoing packet bits
`timescale 1ns/1ps
`include "ulpi_phy_consts.vh"
module tx_line_coder (
	input  wire clk,
	input  wire rstn,
	input  wire bit_en,
	input  wire bit_in,
	input  wire raw,
	input  wire frame,
	output wire take,
	output reg  line_q
);
	reg [2:0] ones_q;
	wire stuff = !raw && (ones_q == `STUFF_LIMIT);
	assign take = bit_en && !stuff;
	always @(posedge clk) begin
		if (!rstn) begin
			ones_q <= 3'h0;
			line_q <= 1'b1;
		end else if (!frame) begin
			ones_q <= 3'h0;
			line_q <= 1'b1;
		end else if (bit_en) begin
			if (raw) begin
				line_q <= bit_in;
				ones_q <= 3'h0;
			end else if (stuff) begin
				line_q <= !line_q;
				ones_q <= 3'h0;
			end else begin
				line_q <= bit_in ? line_q : !line_q;
				ones_q <= bit_in ? ones_q + 3'h1 : 3'h0;
			end
		end
	end
endmodule // tx_line_coder

// *** ulpi_phy_core.v ***
// ulpi phy protocol core: rx command byte and transmit framing
`timescale 1ns/1ps
`include "ulpi_phy_consts.vh"
module ulpi_phy_core (
	input  wire       clk,
	input  wire       rstn,
	input  wire [7:0] ulpi_data_in,
	output reg  [7:0] ulpi_data_out_q,
	output reg        ulpi_data_oe_q,
	output reg        dir_q,
	output reg        nxt_q,
	input  wire       stp,
	input  wire [1:0] transceiver_select,
	input  wire       termination_select,
	input  wire [1:0] operating_mode_field,
	input  wire       dplus_pulldown_enable,
	input  wire       dminus_pulldown_enable,
	input  wire       dp_rx,
	input  wire       dm_rx,
	input  wire       session_end_flag,
	input  wire       session_valid_flag,
	input  wire       supply_valid_flag,
	input  wire       id_pin,
	input  wire       rx_active,
	input  wire       receive_error_flag,
	input  wire       host_unplug_flag,
	input  wire [7:0] carkit_latch,
	input  wire [7:0] carkit_mask,
	output reg        tx_line_q,
	output reg        tx_drive_q,
	output reg        tx_hs_q
);
	localparam ST_IDLE = 3'h0;
	localparam ST_TURN = 3'h1;
	localparam ST_RXC  = 3'h2;
	localparam ST_BACK = 3'h3;
	localparam ST_TXD  = 3'h4;

	reg  [2:0] st_q;
	reg  [2:0] st_d;
	reg  [7:0] snap_q;
	reg        pend_q;
	reg        tx_busy_q;
	reg        tx_stp_q;
	reg  [1:0] ph_q;
	reg  [5:0] sync_q;
	reg  [2:0] bidx_q;
	reg  [7:0] shreg_q;
	reg        shv_q;
	reg  [8:0] div_q;
	reg        bit_en_q;
	reg        cmd_q;

	// supply band encoding
	function [1:0] vbus_enc;
		input se;
		input sv;
		input vv;
		begin
			if (vv)
				vbus_enc = `VB_SUPPLY_OK;
			else if (sv)
				vbus_enc = `VB_SESS_OK;
			else if (se)
				vbus_enc = `VB_BELOW_END;
			else
				vbus_enc = `VB_SESS_LOW;
		end
	endfunction

	wire [1:0] ev = host_unplug_flag ? `EV_UNPLUG :
		(rx_active ? (receive_error_flag ? `EV_ERROR : `EV_ACTIVE) : `EV_NONE);
	wire alt = |(carkit_latch & carkit_mask);
	wire [7:0] rxcmd = {alt, id_pin, ev,
		vbus_enc(session_end_flag, session_valid_flag, supply_valid_flag),
		dm_rx, dp_rx};
	wire changed = (rxcmd != snap_q);

	// decoded operation
	wire chirp = (operating_mode_field == `OPM_CHIRP);
	wire hs    = (transceiver_select == `XS_HS) && !termination_select;
	wire nodrv = (operating_mode_field == `OPM_NODRIVE);
	wire host  = dplus_pulldown_enable && dminus_pulldown_enable;

	// transmit byte path through fifo
	wire       f_in_ready;
	wire [7:0] f_data;
	wire       f_valid;
	wire       f_empty;
	wire       take;
	wire       coded;
	wire       load = !shv_q || (take && bidx_q == 3'h7 && sync_q == 6'h00);
	wire       f_pop = f_valid && load && ph_q == 2'h2;
	wire       txcmd = (ulpi_data_in[7:6] == `TXCMD_TX);
	// first nxt cycle takes the tx command itself, not a data byte
	wire       accept = (st_q == ST_TXD) && nxt_q && !stp && !cmd_q;

	sync_fifo #(
		.WIDTH (`DATA_W),
		.DEPTH (`FIFO_DEPTH),
		.AW    (`FIFO_AW)
	) u_fifo (
		.clk       (clk),
		.rstn      (rstn),
		.in_data   (ulpi_data_in),
		.in_valid  (accept),
		.in_ready  (f_in_ready),
		.out_data  (f_data),
		.out_valid (f_valid),
		.out_ready (f_pop),
		.empty     (f_empty)
	);

	wire sync_bit = (sync_q == 6'h01); // sync ends in a one
	wire cur_bit  = (sync_q != 6'h00) ? sync_bit : shreg_q[bidx_q];
	wire framing  = tx_busy_q && (ph_q != 2'h0);
	// no stale bits shifted out once the last byte is spent
	wire have_bit = (sync_q != 6'h00) || shv_q;

	tx_line_coder u_coder (
		.clk    (clk),
		.rstn   (rstn),
		.bit_en (bit_en_q && framing && have_bit),
		.bit_in (cur_bit),
		.raw    (chirp),
		.frame  (framing),
		.take   (take),
		.line_q (coded)
	);

	// bit-rate enable: hs every cycle, fs and ls divided
	always @(posedge clk) begin
		if (!rstn) begin
			div_q    <= 9'h000;
			bit_en_q <= 1'b0;
		end else if (hs) begin
			div_q    <= 9'h000;
			bit_en_q <= 1'b1;
		end else if (div_q == 9'h000) begin
			div_q    <= transceiver_select[1] ? `LS_DIV : {3'h0, `FS_DIV};
			bit_en_q <= 1'b1;
		end else begin
			div_q    <= div_q - 9'h001;
			bit_en_q <= 1'b0;
		end
	end

	// bus ownership sequencer
	always @* begin
		st_d = st_q;
		case (st_q)
			ST_IDLE: begin
				if (txcmd && !tx_busy_q)
					st_d = ST_TXD;
				else if ((changed || pend_q) && !tx_busy_q)
					st_d = ST_TURN;
			end
			ST_TURN: st_d = ST_RXC;
			ST_RXC:  st_d = ST_BACK;
			ST_BACK: st_d = ST_IDLE;
			ST_TXD: begin
				if (stp)
					st_d = ST_IDLE;
			end
			default: st_d = ST_IDLE;
		endcase
	end

	always @(posedge clk) begin
		if (!rstn) begin
			st_q            <= ST_IDLE;
			snap_q          <= 8'h00;
			pend_q          <= 1'b1;
			dir_q           <= 1'b0;
			nxt_q           <= 1'b0;
			ulpi_data_out_q <= `ULPI_IDLE;
			ulpi_data_oe_q  <= 1'b0;
			cmd_q           <= 1'b0;
		end else begin
			st_q <= st_d;
			cmd_q <= (st_q == ST_IDLE) && (st_d == ST_TXD);
			// change seen while link owns the bus is held, not lost
			if (st_q == ST_RXC)
				pend_q <= 1'b0;
			else if (changed && st_q != ST_IDLE)
				pend_q <= 1'b1;
			if (st_q == ST_TURN)
				snap_q <= rxcmd;
			dir_q           <= (st_d == ST_TURN) || (st_d == ST_RXC);
			ulpi_data_oe_q  <= (st_d == ST_RXC);
			ulpi_data_out_q <= (st_d == ST_RXC) ? rxcmd : `ULPI_IDLE;
			nxt_q           <= (st_d == ST_TXD) && f_in_ready && !stp;
		end
	end

	// packet framer: ph 0 idle, 1 sync, 2 data, 3 drain
	always @(posedge clk) begin
		if (!rstn) begin
			tx_busy_q <= 1'b0;
			tx_stp_q  <= 1'b0;
			ph_q      <= 2'h0;
			sync_q    <= 6'h00;
			bidx_q    <= 3'h0;
			shreg_q   <= 8'h00;
			shv_q     <= 1'b0;
			tx_line_q <= 1'b1;
			tx_drive_q <= 1'b0;
			tx_hs_q   <= 1'b0;
		end else begin
			// idle level whenever the transmitter is not driving
			tx_line_q  <= (framing && !nodrv) ? coded : 1'b1;
			tx_drive_q <= framing && !nodrv;
			tx_hs_q    <= hs;
			if (st_q == ST_TXD && stp)
				tx_stp_q <= 1'b1;
			case (ph_q)
				2'h0: begin
					tx_stp_q <= 1'b0;
					if (st_q == ST_IDLE && txcmd && !tx_busy_q) begin
						tx_busy_q <= 1'b1;
						ph_q      <= 2'h1;
						sync_q    <= (hs && !chirp) ? `SYNC_HS_BITS : `SYNC_FL_BITS;
						shreg_q   <= {~ulpi_data_in[3:0], ulpi_data_in[3:0]};
						shv_q     <= 1'b1;
						bidx_q    <= 3'h0;
					end
				end
				2'h1, 2'h2: begin
					if (take) begin
						if (sync_q != 6'h00) begin
							sync_q <= sync_q - 6'h01;
							if (sync_q == 6'h01)
								ph_q <= 2'h2;
						end else begin
							bidx_q <= bidx_q + 3'h1;
							if (bidx_q == 3'h7)
								shv_q <= 1'b0;
						end
					end
					if (f_pop) begin
						shreg_q <= f_data;
						shv_q   <= 1'b1;
					end else if (!shv_q && tx_stp_q && f_empty)
						ph_q <= 2'h3;
				end
				2'h3: begin
					ph_q      <= 2'h0;
					tx_busy_q <= 1'b0;
				end
				default: ph_q <= 2'h0;
			endcase
		end
	end

	wire unused_ok = host;
endmodule // ulpi_phy_core

// *** ulpi_phy_core_properties.sv ***
// assertion checker for the rx command byte and the bus turnaround
`timescale 1ns/1ps
module ulpi_phy_core_properties (
	input wire       clk,
	input wire       rstn,
	input wire [7:0] ulpi_data_out_q,
	input wire       ulpi_data_oe_q,
	input wire       dir_q,
	input wire       nxt_q,
	input wire       dp_rx,
	input wire       dm_rx,
	input wire       id_pin,
	input wire       tx_line_q,
	input wire       tx_drive_q
);
	wire [2:0] src = {id_pin, dm_rx, dp_rx};
	reg  [2:0] s1_q;
	reg  [2:0] s2_q;
	// the byte is captured one cycle before it is shown
	wire       stab = (src == s1_q) && (s1_q == s2_q);
	always @(posedge clk) begin
		s1_q <= src;
		s2_q <= s1_q;
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	AST_LINE: assert property (ulpi_data_oe_q && stab |-> ulpi_data_out_q[1:0] == src[1:0])
		else $error("line state field wrong");
	AST_ID: assert property (ulpi_data_oe_q && stab |-> ulpi_data_out_q[6] == id_pin)
		else $error("id field wrong");
	AST_QUIET: assert property (!ulpi_data_oe_q |-> ulpi_data_out_q == 8'h00)
		else $error("data driven while not enabled");
	AST_TURN: assert property ($rose(ulpi_data_oe_q) |-> dir_q && $past(dir_q))
		else $error("rx command without turnaround");
	AST_DIR_SEQ: assert property ($rose(dir_q) |=> ulpi_data_oe_q ##1 !dir_q && !ulpi_data_oe_q)
		else $error("rx command cycle sequence wrong");
	AST_NO_RX_IN_TX: assert property (nxt_q |-> !dir_q && !ulpi_data_oe_q)
		else $error("rx command during transmit");
	AST_SEND: assert property ($changed(src) && !dir_q && !nxt_q && !tx_drive_q
		|-> ##[1:6] ulpi_data_oe_q) else $error("line change not reported");
	AST_IDLE_J: assert property (!tx_drive_q |-> tx_line_q)
		else $error("idle line not high");
endmodule // ulpi_phy_core_properties
bind ulpi_phy_core ulpi_phy_core_properties i_props (.*);

// *** link_model.sv ***
// link side model that sends transmit packets over the ulpi bus
`timescale 1ns/1ps
module link_model (
	input  wire       clk,
	input  wire       dir_q,
	input  wire       nxt_q,
	output wire [7:0] ulpi_data_in,
	output reg        stp = 1'b0
);
	reg [7:0] bus_q = 8'h00;
	// a released bus must not keep showing the last byte
	assign ulpi_data_in = dir_q ? ~bus_q : bus_q;
	task send(input [3:0] pid, input integer nb);
		integer i;
		begin
			i = 0;
			@(posedge clk);
			while (dir_q) @(posedge clk);
			bus_q <= {4'h4, pid};
			while (i <= nb) begin
				@(posedge clk);
				if (nxt_q) begin
					i = i + 1;
					bus_q <= (i > nb) ? 8'h00 : 8'hff;
					stp <= i > nb;
				end
			end
			@(posedge clk) stp <= 1'b0;
		end
	endtask
endmodule // link_model

// *** ulpi_rxcmd_and_tx_framing_tb.sv ***
// self-checking bench for the rx command and transmit framing core
`timescale 1ns/1ps
module ulpi_rxcmd_and_tx_framing_tb;
	localparam [143:0] CASES = {12'h005, 12'h009, 12'h019, 12'h039, 12'h079, 12'h0f9,
		12'h1f9, 12'h038, 12'h03b, 12'h239, 12'h639, 12'ha39};
	reg        clk = 1'b0, rstn = 1'b0, termination_select = 1'b0;
	reg        dplus_pulldown_enable = 1'b0, dminus_pulldown_enable = 1'b0;
	reg [1:0]  transceiver_select = 2'h0, operating_mode_field = 2'h0;
	reg [11:0] cfg = 12'h001;
	wire [7:0] ulpi_data_in, ulpi_data_out_q, carkit_latch, carkit_mask;
	wire       ulpi_data_oe_q, dir_q, nxt_q, stp, tx_line_q, tx_drive_q, tx_hs_q;
	wire       dp_rx, dm_rx, session_end_flag, session_valid_flag, supply_valid_flag;
	wire       id_pin, rx_active, receive_error_flag, host_unplug_flag;
	integer    errors = 0, comparisons = 0, n, gmax, bt, bt_hs, rxdur;
	assign {host_unplug_flag, receive_error_flag, rx_active, id_pin, supply_valid_flag,
		session_valid_flag, session_end_flag, dm_rx, dp_rx} = cfg[8:0];
	assign carkit_latch = {2'h0, cfg[11], 4'h0, cfg[9]};
	assign carkit_mask = {7'h00, cfg[10]};
	always #5 clk = ~clk;
	ulpi_phy_core i_dut (.*);
	link_model i_link (.*);
	function [7:0] rxb(input [11:0] c);
		rxb = {c[9] & c[10], c[5], c[8] ? 2'h2 : {c[7] & c[6], c[6]},
			c[4] ? 2'h3 : c[3] ? 2'h2 : {1'b0, ~c[2]}, c[1:0]};
	endfunction
	task report_and_stop;
		begin
			$display("errors=%0d comparisons=%0d", errors, comparisons);
			if (errors == 0 && comparisons > 0)
				$display("Finished cleanly");
			else
				$display("Finished with errors");
			$finish;
		end
	endtask
	task chk(input [31:0] g, input [31:0] e);
		begin
			comparisons = comparisons + 1;
			if (g !== e) begin
				errors = errors + 1;
				$display("BAD t=%0t got=%h exp=%h", $time, g, e);
			end
		end
	endtask
	task wait_rx(input [7:0] e);
		integer i;
		begin
			i = 0;
			do begin
				@(posedge clk) #1;
				i = i + 1;
			end while (ulpi_data_oe_q !== 1'b1 && i < 8);
			chk({ulpi_data_oe_q, ulpi_data_out_q}, {1'b1, e});
		end
	endtask
	task rx_cases;
		integer i;
		begin
			for (i = 0; i < 12; i = i + 1) begin
				@(posedge clk) cfg <= CASES[(11 - i) * 12 +: 12];
				wait_rx(rxb(CASES[(11 - i) * 12 +: 12]));
				if (ulpi_data_out_q[7]) chk(carkit_latch & carkit_mask, 8'h01);
			end
		end
	endtask
	// sync length is the run of evenly spaced toggles before the first longer gap
	task frame(input [1:0] xs, input ts, input [1:0] op, input integer nb);
		integer k, gap, t;
		reg     prev, s;
		begin
			@(posedge clk) transceiver_select <= xs;
			termination_select <= ts;
			operating_mode_field <= op;
			repeat (3) @(posedge clk);
			#1 chk(tx_hs_q, xs == 2'h0 && ts == 1'b0);
			fork
				i_link.send(4'h3, nb);
				begin
					n = 0;
					gap = 0;
					gmax = 0;
					t = 0;
					prev = 1'b1;
					s = 1'b1;
					rxdur = 0;
					for (k = 0; k < 60 && tx_drive_q !== 1'b1; k = k + 1) @(posedge clk) #1;
					while (tx_drive_q === 1'b1 && k < 30000) begin
						@(posedge clk) #1;
						k = k + 1;
						gap = gap + 1;
						if (ulpi_data_oe_q === 1'b1) rxdur = rxdur + 1;
						if (tx_line_q !== prev) begin
							prev = tx_line_q;
							if (n == 1) t = gap;
							if (s) n = n + 1;
							gap = 0;
						end else if (n > 1 && gap > t) s = 1'b0;
						if (gap > gmax) gmax = gap;
					end
					bt = t;
				end
			join
		end
	endtask
	task tx_hs;
		integer k;
		begin
			fork
				frame(2'h0, 1'b0, 2'h0, 4);
				begin
					for (k = 0; k < 200 && tx_drive_q !== 1'b1; k = k + 1) @(posedge clk) #1;
					@(posedge clk) cfg <= 12'h002;
				end
			join
			bt_hs = bt;
			chk(n, 31);
			chk(gmax <= 8 * bt, 1);
			chk(rxdur, 0);
			wait_rx(rxb(12'h002));
		end
	endtask
	task tx_chirp;
		begin
			frame(2'h0, 1'b1, 2'h2, 4);
			chk(gmax > 8 * bt_hs, 1);
		end
	endtask
	task tx_slow;
		begin
			frame(2'h1, 1'b1, 2'h0, 2);
			chk(n, 7);
			frame(2'h2, 1'b1, 2'h0, 1);
			chk(n, 7);
		end
	endtask
	initial begin
		#500000;
		errors = errors + 1;
		report_and_stop;
	end
	initial begin
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		wait_rx(rxb(12'h001));
		rx_cases;
		tx_hs;
		tx_chirp;
		tx_slow;
		report_and_stop;
	end
endmodule // ulpi_rxcmd_and_tx_framing_tb
